// >>> rtl/crp_readout.sv
// class readout post-processor: moving averages, max search, pin report
// assumes synchronous inputs on ref_clk and a classic Wishbone master
// What this block does
// - average per class, find max, compare threshold
// - slow clock paces average updates
// - interrupt low while max not above threshold and force-report off
// - force-report raises interrupt every slow tick
// - interrupt rises only at slow falling edge
// - index pins active only on hit or force
// - index pins show binary max class index
// - accept spikes with destination twelve when enabled
// - two-bit selection of four neuron address layouts
// - comparison positive only when strictly greater
// - window sixteen or thirty-two slow periods
// - filter on after reset, bypass gives one
// - pin watching reports index with microsecond stamp
// - 21-bit result word each slow cycle
// - mode zero holds low field at zero
// - mode one puts comparison bits low
// - mode two selected average, valid after compute
// - mode three puts largest average low
// - one slow clock drives leak, filter, readout
// - internal clock counts vision sensor events
// - event count exponent fourteen to seventeen
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
module crp_readout
  import crp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic spikeValid,
  input wire logic [3:0] spikeDest,
  input wire logic [1:0] spikeX,
  input wire logic [1:0] spikeY,
  input wire logic [3:0] spikeF,
  input wire logic dvsEvent,
  input wire logic slowClkExt,
  output logic slowClkOut,
  output logic intOut,
  output logic [3:0] classIndexPins,
  output logic [CRP_RESW-1:0] resultWord,
  output logic pinEvtValid,
  output logic [3:0] pinEvtIndex,
  output logic [31:0] pinEvtTime
);
  logic [31:0] ctrl_q;
  logic [15:0] thresh_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [CRP_DIVW-1:0] divCnt_q;
  logic slowInt_q;
  logic slowClk_q;
  logic slowPrev_q;
  logic pend_q;
  crp_state_t state_q;
  logic [3:0] srch_q;
  logic [15:0] bestAvg_q;
  logic [3:0] bestIdx_q;
  logic [CRP_NCLASS-1:0] cmp_q;
  logic [CRP_CNTW-1:0] cnt_q [CRP_NCLASS];
  logic [CRP_CNTW-1:0] snap_q [CRP_NCLASS];
  logic [CRP_ACCW-1:0] acc_q [CRP_NCLASS];
  logic [15:0] avg_q [CRP_NCLASS];
  logic intOut_q;
  logic [3:0] pins_q;
  logic [CRP_RESW-1:0] res_q;
  logic evtValid_q;
  logic [3:0] evtIdx_q;
  logic [31:0] evtTime_q;
  logic [6:0] usPre_q;
  logic [31:0] usTime_q;

  logic ctrlEn, ctrlForce, ctrlLong, ctrlBypass, ctrlPinMon, ctrlExt;
  logic [1:0] ctrlAddr, ctrlMode, ctrlDiv;
  logic [3:0] ctrlSelN;
  logic [2:0] winShift;
  logic [CRP_DIVW-1:0] divHalf;
  logic tick, take, spikeTaken, maxHit, reportOn;
  logic [3:0] spikeCls;
  logic [15:0] avgCur;
  logic [31:0] wrMask;
  logic busAcc;

  assign ctrlEn = ctrl_q[CRP_C_EN];
  assign ctrlForce = ctrl_q[CRP_C_FORCE];
  assign ctrlLong = ctrl_q[CRP_C_LONGWIN];
  assign ctrlBypass = ctrl_q[CRP_C_BYPASS];
  assign ctrlPinMon = ctrl_q[CRP_C_PINMON];
  assign ctrlExt = ctrl_q[CRP_C_EXTCLK];
  assign ctrlAddr = ctrl_q[CRP_C_ADDR +: 2];
  assign ctrlMode = ctrl_q[CRP_C_MODE +: 2];
  assign ctrlDiv = ctrl_q[CRP_C_DIV +: 2];
  assign ctrlSelN = ctrl_q[CRP_C_SELN +: 4];

  // bus slave: one wait state, ack for one cycle, unmapped reads zero
  assign busAcc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      ack_q <= 1'b0;
    else
      ack_q <= busAcc;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      ctrl_q <= CRP_CTRL_RST;
      thresh_q <= CRP_THRESH_RST;
    end
    else if (busAcc && wb_we_i)
    begin
      if (wb_adr_i == CRP_OFF_CTRL)
        ctrl_q <= ((ctrl_q & ~wrMask) | (wb_dat_i & wrMask))
                  & CRP_CTRL_MASK;
      if (wb_adr_i == CRP_OFF_THRESH)
        thresh_q <= (thresh_q & ~wrMask[15:0])
                    | (wb_dat_i[15:0] & wrMask[15:0]);
    end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      rdat_q <= 32'h0;
    else if (busAcc && !wb_we_i)
    begin
      unique case (wb_adr_i)
        CRP_OFF_CTRL: rdat_q <= ctrl_q;
        CRP_OFF_THRESH: rdat_q <= {16'h0, thresh_q};
        CRP_OFF_RESULT: rdat_q <= {11'h0, res_q};
        CRP_OFF_STATUS:
          rdat_q <= {20'h0, bestIdx_q, pins_q, 2'h0, intOut_q,
                     state_q != CRP_IDLE};
        default: rdat_q <= 32'h0;
      endcase
    end

  // internal slow clock: toggles every 2^(exp-1) vision events
  assign divHalf = CRP_DIVW'(1) << (CRP_DIV_EXP_MIN - 1 + int'(ctrlDiv));

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      divCnt_q <= '0;
      slowInt_q <= 1'b0;
    end
    else if (dvsEvent)
    begin
      if (divCnt_q >= divHalf - CRP_DIVW'(1))
      begin
        divCnt_q <= '0;
        slowInt_q <= !slowInt_q;
      end
      else
        divCnt_q <= divCnt_q + CRP_DIVW'(1);
    end

  // one shared source, also driven out to leak and filter logic
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      slowClk_q <= 1'b0;
      slowPrev_q <= 1'b0;
    end
    else
    begin
      slowClk_q <= ctrlExt ? slowClkExt : slowInt_q;
      slowPrev_q <= slowClk_q;
    end

  assign tick = slowPrev_q && !slowClk_q;
  assign take = (state_q == CRP_IDLE) && (tick || pend_q);

  // a tick during computation is held, not lost
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      pend_q <= 1'b0;
    else if (take)
      pend_q <= 1'b0;
    else if (tick)
      pend_q <= 1'b1;

  // address layout to class index
  always_comb
  begin
    unique case (ctrlAddr)
      2'h0: spikeCls = {spikeF[1:0], spikeY[0], spikeX[0]};
      2'h1: spikeCls = {spikeF[0], spikeY[1:0], spikeX[0]};
      2'h2: spikeCls = {spikeY[1:0], spikeX[1:0]};
      2'h3: spikeCls = spikeF;
    endcase
  end

  assign spikeTaken = spikeValid && ctrlEn
                      && (spikeDest == CRP_READOUT_DEST);
  assign winShift = ctrlLong ? CRP_SHIFT_LONG : CRP_SHIFT_SHORT;

  genvar gi;
  generate
    for (gi = 0; gi < CRP_NCLASS; gi++)
    begin : g_cls
      logic hit;
      logic [CRP_CNTW:0] cntInc;
      logic [CRP_ACCW:0] accNext;
      assign hit = spikeTaken && (spikeCls == 4'(gi));
      assign cntInc = {1'b0, cnt_q[gi]} + {{CRP_CNTW{1'b0}}, hit};
      assign accNext = {1'b0, acc_q[gi]} - {1'b0, acc_q[gi] >> winShift}
                       + {{(CRP_ACCW-CRP_CNTW+1){1'b0}}, snap_q[gi]};

      // per-period spike count, saturating; snapshot at the tick
      always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
          cnt_q[gi] <= '0;
          snap_q[gi] <= '0;
        end
        else if (take)
        begin
          snap_q[gi] <= cntInc[CRP_CNTW] ? '1 : cntInc[CRP_CNTW-1:0];
          cnt_q[gi] <= '0;
        end
        else if (hit && !cntInc[CRP_CNTW])
          cnt_q[gi] <= cntInc[CRP_CNTW-1:0];

      // leaky accumulator holds average scaled by window length
      always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
        begin
          acc_q[gi] <= '0;
          avg_q[gi] <= '0;
        end
        else if (state_q == CRP_UPDATE)
        begin
          if (ctrlBypass)
          begin
            acc_q[gi] <= '0;
            avg_q[gi] <= snap_q[gi];
          end
          else
          begin
            acc_q[gi] <= accNext[CRP_ACCW-1:0];
            avg_q[gi] <= 16'(accNext[CRP_ACCW-1:0] >> winShift);
          end
        end
    end
  endgenerate

  // sequencer: update all, then walk classes one per cycle for the max
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      state_q <= CRP_IDLE;
      srch_q <= '0;
    end
    else
    begin
      unique case (state_q)
        CRP_IDLE:
          if (take)
            state_q <= CRP_UPDATE;
        CRP_UPDATE:
        begin
          srch_q <= '0;
          state_q <= CRP_SEARCH;
        end
        CRP_SEARCH:
        begin
          srch_q <= srch_q + 4'h1;
          if (srch_q == 4'(CRP_NCLASS - 1))
            state_q <= CRP_REPORT;
        end
        CRP_REPORT:
          state_q <= CRP_IDLE;
      endcase
    end

  assign avgCur = avg_q[srch_q];

  // first class wins a tie
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      bestAvg_q <= '0;
      bestIdx_q <= '0;
      cmp_q <= '0;
    end
    else if (state_q == CRP_SEARCH)
    begin
      if (srch_q == 4'h0 || avgCur > bestAvg_q)
      begin
        bestAvg_q <= avgCur;
        bestIdx_q <= srch_q;
      end
      cmp_q[srch_q] <= avgCur > thresh_q;
    end

  assign maxHit = bestAvg_q > thresh_q;
  assign reportOn = ctrlForce || maxHit;

  // pins and interrupt move only at the report after a falling edge
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      intOut_q <= 1'b0;
      pins_q <= '0;
    end
    else if (state_q == CRP_REPORT)
    begin
      intOut_q <= reportOn;
      pins_q <= reportOn ? bestIdx_q : 4'h0;
    end

  // valid drops while a new result is computed
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      res_q <= '0;
    else if (take)
      res_q[CRP_RES_VALID] <= 1'b0;
    else if (state_q == CRP_REPORT)
    begin
      res_q[CRP_RES_VALID] <= 1'b1;
      res_q[CRP_RES_IDX +: 4] <= bestIdx_q;
      unique case (ctrlMode)
        CRP_MODE_OFF: res_q[15:0] <= 16'h0;
        CRP_MODE_CMP: res_q[15:0] <= cmp_q;
        CRP_MODE_SEL: res_q[15:0] <= avg_q[ctrlSelN];
        CRP_MODE_MAX: res_q[15:0] <= bestAvg_q;
      endcase
    end

  // microsecond timestamp for pin events
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      usPre_q <= '0;
      usTime_q <= '0;
    end
    else if (usPre_q == 7'(CRP_US_CYC - 1))
    begin
      usPre_q <= '0;
      usTime_q <= usTime_q + 32'h1;
    end
    else
      usPre_q <= usPre_q + 7'h1;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      evtValid_q <= 1'b0;
      evtIdx_q <= '0;
      evtTime_q <= '0;
    end
    else
    begin
      evtValid_q <= (state_q == CRP_REPORT) && ctrlPinMon
                    && reportOn;
      if (state_q == CRP_REPORT && ctrlPinMon && reportOn)
      begin
        evtIdx_q <= bestIdx_q;
        evtTime_q <= usTime_q;
      end
    end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign slowClkOut = slowClk_q;
  assign intOut = intOut_q;
  assign classIndexPins = pins_q;
  assign resultWord = res_q;
  assign pinEvtValid = evtValid_q;
  assign pinEvtIndex = evtIdx_q;
  assign pinEvtTime = evtTime_q;

  a_calc_length: assert property (@(posedge ref_clk) disable iff (!rstn)
    take |-> ##18 state_q == CRP_REPORT)
    else $error("report not 18 cycles after tick");
  a_int_low_miss: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_REPORT && !ctrlForce && !maxHit |=> !intOut_q)
    else $error("interrupt high without threshold hit");
  a_force_int: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_REPORT && ctrlForce |=> intOut_q && pinEvtValid
      == $past(ctrlPinMon))
    else $error("force report did not raise interrupt");
  a_int_rise_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(intOut_q) |-> $past(state_q == CRP_REPORT))
    else $error("interrupt rose outside report");
  a_pins_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_REPORT && !reportOn |=> classIndexPins == 4'h0)
    else $error("index pins active without hit");
  a_pins_index: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_REPORT && reportOn
      |=> classIndexPins == $past(bestIdx_q))
    else $error("index pins differ from max class");
  a_strict_cmp: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_SEARCH && avgCur == thresh_q
      |=> !cmp_q[$past(srch_q)])
    else $error("equal average counted as above threshold");
  a_bypass_avg: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_UPDATE && ctrlBypass
      |=> avg_q[0] == $past(snap_q[0]))
    else $error("bypass average is not last period count");
  a_valid_late: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(res_q[CRP_RES_VALID]) |-> $past(state_q == CRP_REPORT))
    else $error("data valid before computation done");
  a_mode_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_q == CRP_REPORT && ctrlMode == CRP_MODE_OFF
      |=> res_q[15:0] == 16'h0)
    else $error("low field not zero in mode zero");
  a_ext_clk: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlExt |=> slowClk_q == $past(slowClkExt))
    else $error("slow clock not following external input");
endmodule

// >>> pkg/crp_pkg.sv
// constants, register map and types of the class readout post-processor
// assumes a 100 MHz system clock and a 32-bit classic Wishbone slave port
package crp_pkg;
  localparam int CRP_NCLASS = 16;
  localparam int CRP_IDXW = 4;
  localparam int CRP_CNTW = 16;
  localparam int CRP_ACCW = 21;
  localparam logic [3:0] CRP_READOUT_DEST = 4'hc;
  // register byte offsets
  localparam logic [3:0] CRP_OFF_CTRL = 4'h0;
  localparam logic [3:0] CRP_OFF_THRESH = 4'h4;
  localparam logic [3:0] CRP_OFF_RESULT = 4'h8;
  localparam logic [3:0] CRP_OFF_STATUS = 4'hc;
  // control register fields
  localparam int CRP_C_EN = 0;
  localparam int CRP_C_FORCE = 1;
  localparam int CRP_C_LONGWIN = 2;
  localparam int CRP_C_BYPASS = 3;
  localparam int CRP_C_PINMON = 4;
  localparam int CRP_C_EXTCLK = 5;
  localparam int CRP_C_ADDR = 8;
  localparam int CRP_C_MODE = 12;
  localparam int CRP_C_DIV = 16;
  localparam int CRP_C_SELN = 20;
  localparam logic [31:0] CRP_CTRL_RST = 32'h0;
  localparam logic [31:0] CRP_CTRL_MASK = 32'h00f3333f;
  localparam logic [15:0] CRP_THRESH_RST = 16'h0;
  // status register fields
  localparam int CRP_S_BUSY = 0;
  localparam int CRP_S_INT = 1;
  localparam int CRP_S_PINS = 4;
  localparam int CRP_S_MAX = 8;
  // averaging window shifts: 16 and 32 slow periods
  localparam logic [2:0] CRP_SHIFT_SHORT = 3'h4;
  localparam logic [2:0] CRP_SHIFT_LONG = 3'h5;
  // divider: half period is 2^(exp-1), exp = 14 + field
  localparam int CRP_DIV_EXP_MIN = 14;
  localparam int CRP_DIVW = 17;
  // result word layout
  localparam int CRP_RESW = 21;
  localparam int CRP_RES_VALID = 20;
  localparam int CRP_RES_IDX = 16;
  // output modes
  localparam logic [1:0] CRP_MODE_OFF = 2'h0;
  localparam logic [1:0] CRP_MODE_CMP = 2'h1;
  localparam logic [1:0] CRP_MODE_SEL = 2'h2;
  localparam logic [1:0] CRP_MODE_MAX = 2'h3;
  // timestamp timing
  localparam int CRP_CLK_PERIOD_NS = 10;
  localparam int CRP_TS_UNIT_NS = 1000;
  localparam int CRP_US_CYC = CRP_TS_UNIT_NS / CRP_CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    CRP_IDLE,
    CRP_UPDATE,
    CRP_SEARCH,
    CRP_REPORT
  } crp_state_t;
endpackage

// >>> tb/crp_pin_monitor.sv
// external controller model polling the interrupt and class index pins
// assumes the pins are registered levels on ref_clk
`timescale 1ns/1ns
module crp_pin_monitor
(
  input wire logic ref_clk,
  input wire logic intOut,
  input wire logic [3:0] classIndexPins,
  output logic [3:0] seenIdx
);
  initial seenIdx = 4'h0;
  // index only trusted while the interrupt stands
  always @(posedge ref_clk)
    if (intOut === 1'b1)
    begin
      seenIdx <= classIndexPins;
    end
endmodule

// >>> tb/crp_readout_test.sv
// self-checking bench of the class readout post-processor
// assumes crp_pkg and the pin monitor model are compiled before it
`timescale 1ns/1ns
module crp_readout_test;
  import crp_pkg::*;
  typedef struct packed {
    logic i;
    logic [3:0] p;
    logic [20:0] w;
    logic e;
  } crp_note_t;
  logic ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic sv = 0, dvs = 0, ext = 0, prevValid = 0;
  logic [3:0] adr = 0, sel = 0, dest = 0, sf = 0;
  logic [1:0] sx = 0, sy = 0;
  logic [31:0] wdat = 0, rdo, ptime, rd;
  logic ack, slowOut, intO, pev;
  logic [3:0] pins, pidx, seen;
  logic [20:0] word;
  int mismatches = 0, checks = 0, seed = 40822;
  int avg[16];
  crp_note_t q[$];
  crp_note_t cur, nx;
  // release edge of the latest reset, base of the microsecond stamp
  time tRel = 0;

  crp_readout crp_readout_i (.ref_clk(ref_clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .spikeValid(sv), .spikeDest(dest), .spikeX(sx), .spikeY(sy),
    .spikeF(sf), .dvsEvent(dvs), .slowClkExt(ext), .slowClkOut(slowOut),
    .intOut(intO), .classIndexPins(pins), .resultWord(word),
    .pinEvtValid(pev), .pinEvtIndex(pidx), .pinEvtTime(ptime));
  crp_pin_monitor crp_pin_monitor_i (.ref_clk(ref_clk), .intOut(intO),
    .classIndexPins(pins), .seenIdx(seen));

  initial
    forever #5 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: whole run is about 17k cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // no local limit: only the watchdog ends a hung wait
    @(posedge ref_clk);
    while (ack !== 1'b1)
      @(posedge ref_clk);
    rd = rdo;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge ref_clk);
    check(ack, 0);
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    wb(0, a, 0);
    check(rd, e);
  endtask

  task automatic spk(input logic [1:0] x, input logic [1:0] y,
    input logic [3:0] f, input int n, input logic [3:0] d);
    repeat (n)
    begin
      sv <= 1;
      dest <= d;
      sx <= x;
      sy <= y;
      sf <= f;
      @(posedge ref_clk);
    end
    // idle edge so a following burst never re-raises valid in one step
    sv <= 0;
    @(posedge ref_clk);
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (q.size() > 0 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(q.size(), 0);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic tick(input crp_note_t nt);
    q.push_back(nt);
    ext <= 1;
    repeat (4) @(posedge ref_clk);
    ext <= 0;
    waitDone();
    if (nt.i)
      check(seen, nt.p);
  endtask

  function automatic crp_note_t note(input int t, input logic f,
    input int m, input int s, input logic pm);
    crp_note_t nt;
    int mx;
    logic [15:0] lo;
    mx = 0;
    lo = 16'h0;
    for (int c = 1; c < 16; c++)
      if (avg[c] > avg[mx])
        mx = c;
    nt.i = f | (avg[mx] > t);
    nt.p = nt.i ? 4'(mx) : 4'h0;
    for (int c = 0; c < 16; c++)
      if (m == 1)
        lo[c] = avg[c] > t;
    if (m == 2)
      lo = 16'(avg[s]);
    if (m == 3)
      lo = 16'(avg[mx]);
    nt.w = {1'b1, 4'(mx), lo};
    nt.e = pm & nt.i;
    return nt;
  endfunction

  // each report: oldest note against pins, word and pin event
  always @(negedge ref_clk)
  begin
    if (word[CRP_RES_VALID] === 1'b1 && prevValid !== 1'b1)
    begin
      if (q.size() == 0)
        check(0, 1);
      else
      begin
        cur = q.pop_front();
        check(intO, cur.i);
        check(pins, cur.p);
        check(word, cur.w);
        check(pev, cur.e);
        if (cur.e)
        begin
          check(pidx, cur.p);
          check(ptime, 32'(($time - tRel - 15) / CRP_TS_UNIT_NS));
        end
      end
    end
    prevValid = word[CRP_RES_VALID];
  end

  initial
  begin
    logic [1:0] x, y;
    logic [3:0] f, c;
    repeat (20) @(posedge ref_clk);
    rstn <= 1;
    tRel = $time;
    @(posedge ref_clk);
    rdChk(CRP_OFF_CTRL, CRP_CTRL_RST);
    rdChk(CRP_OFF_THRESH, 32'(CRP_THRESH_RST));
    wb(1, CRP_OFF_CTRL, 32'hffffffff);
    rdChk(CRP_OFF_CTRL, CRP_CTRL_MASK);
    wb(1, CRP_OFF_RESULT, 32'h1fffff);
    rdChk(CRP_OFF_RESULT, 32'h0);
    rdChk(4'h6, 32'h0);
    $display("test registers done");
    // window 16 from an empty accumulator, then one decay step
    wb(1, CRP_OFF_CTRL, 32'h3321);
    wb(1, CRP_OFF_THRESH, 32'h2);
    spk(2'($random(seed)), 2'($random(seed)), 4'h5, 64, CRP_READOUT_DEST);
    spk(2'($random(seed)), 2'($random(seed)), 4'h9, 32, CRP_READOUT_DEST);
    spk(2'h0, 2'h0, 4'h7, 80, 4'h3);
    avg = '{default: 0};
    avg[5] = 4;
    avg[9] = 2;
    nx = note(2, 0, 3, 0, 0);
    tick(nx);
    rdChk(CRP_OFF_RESULT, 32'(nx.w));
    wb(0, CRP_OFF_STATUS, 0);
    check(rd & 32'hff2, 32'h552);
    avg[5] = 3;
    avg[9] = 1;
    tick(note(2, 0, 3, 0, 0));
    $display("test short window done");
    // reset in mid-run clears outputs; window 32 average equals threshold
    rstn <= 0;
    repeat (3) @(posedge ref_clk);
    check(word, 0);
    check(intO, 0);
    rstn <= 1;
    tRel = $time;
    @(posedge ref_clk);
    wb(1, CRP_OFF_CTRL, 32'h3335);
    wb(1, CRP_OFF_THRESH, 32'h2);
    spk(2'($random(seed)), 2'($random(seed)), 4'h5, 64, CRP_READOUT_DEST);
    avg = '{default: 0};
    avg[5] = 2;
    tick(note(2, 0, 3, 0, 1));
    $display("test long window done");
    // bypass: all four output modes, tie keeps lowest index
    wb(1, CRP_OFF_THRESH, 32'h5);
    avg = '{default: 0};
    avg[3] = 6;
    avg[9] = 5;
    avg[12] = 6;
    for (int m = 0; m < 4; m++)
    begin
      wb(1, CRP_OFF_CTRL, 32'h900339 | (32'(m) << CRP_C_MODE));
      spk(2'h1, 2'h2, 4'h3, 6, CRP_READOUT_DEST);
      spk(2'h3, 2'h0, 4'h9, 5, CRP_READOUT_DEST);
      spk(2'h0, 2'h3, 4'hc, 6, CRP_READOUT_DEST);
      tick(note(5, 0, m, 9, 1));
    end
    // disabled readout ignores spikes; force still reports
    wb(1, CRP_OFF_CTRL, 32'h3338);
    spk(2'h1, 2'h2, 4'h3, 6, CRP_READOUT_DEST);
    avg = '{default: 0};
    tick(note(5, 0, 3, 0, 1));
    wb(1, CRP_OFF_CTRL, 32'h333a);
    tick(note(5, 1, 3, 0, 1));
    $display("test modes done");
    // four address layouts with random neuron addresses
    wb(1, CRP_OFF_THRESH, 32'h0);
    for (int l = 0; l < 4; l++)
    begin
      wb(1, CRP_OFF_CTRL, 32'h3029 | (32'(l) << CRP_C_ADDR));
      x = 2'($random(seed));
      y = 2'($random(seed));
      f = 4'($random(seed));
      c = (l == 0) ? {f[1:0], y[0], x[0]} : (l == 1) ? {f[0], y, x[0]} :
        (l == 2) ? {y, x} : f;
      spk(x, y, f, 3, CRP_READOUT_DEST);
      avg = '{default: 0};
      avg[c] = 3;
      tick(note(0, 0, 3, 0, 0));
    end
    $display("test layouts done");
    // internal clock from counted sensor events, exponent field 0
    wb(1, CRP_OFF_CTRL, 32'h000b);
    avg = '{default: 0};
    q.push_back(note(0, 1, 0, 0, 0));
    dvs <= 1;
    repeat (8195) @(posedge ref_clk);
    check(slowOut, 1);
    repeat (8189) @(posedge ref_clk);
    dvs <= 0;
    waitDone();
    $display("test internal clock done");
    finish_test();
  end
endmodule
